// ===== design/microcode_store_pkg.sv
// Constants and types shared by the microcode store port
package microcode_store_pkg;
  // ****************************************
  // Store geometry
  // ****************************************
  localparam int unsigned WORD_W = 24;
  localparam int unsigned STORE_DEPTH = 1024;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned MADDR_W = 11;
  localparam int unsigned BUS_W = 22;
  localparam int unsigned SWITCH_W = 8;
  // ****************************************
  // Register indices (byte address is four times)
  // ****************************************
  localparam logic [1:0] STATUS_INDEX = 2'h0;
  localparam logic [1:0] LOAD_LOW_INDEX = 2'h1;
  localparam logic [1:0] LOAD_HIGH_INDEX = 2'h2;
  localparam logic [1:0] LAST_INDEX = 2'h2;
  // ****************************************
  // Control status word fields
  // ****************************************
  localparam int RESET_BIT = 15;
  localparam int EXAMINE_BIT = 14;
  localparam int TOGGLE_BIT = 13;
  localparam int ENABLE_BIT = 12;
  localparam logic [3:0] CONTROL_RESET_VALUE = 4'h0;
  localparam logic [9:0] ADDR_RESET_VALUE = 10'h000;
  // ****************************************
  // Microinstruction bus encodings
  // ****************************************
  localparam logic [3:0] PAGE_TOGGLE_CODE = 4'h7;
  localparam int STORE_DISABLE_LINE = 16;
  // Address switch settings, one position per mode
  localparam logic [7:0] SWITCH_MODE1 = 8'h01;
  localparam logic [7:0] SWITCH_MODE2 = 8'h02;
  localparam logic [7:0] SWITCH_MODE3 = 8'h04;
  localparam logic [7:0] SWITCH_MODE4 = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PHASE_ONE = 2'b00,
    PHASE_TWO = 2'b01,
    PHASE_THREE = 2'b11,
    PHASE_FOUR = 2'b10
  } phase_t;
  typedef enum logic [2:0] {
    MAP_NONE = 3'h0,
    MAP_MODE1 = 3'h1,
    MAP_MODE2 = 3'h2,
    MAP_MODE3 = 3'h3,
    MAP_MODE4 = 3'h4
  } map_mode_t;
endpackage : microcode_store_pkg

// ===== design/microcode_store_port.sv
// Writable microcode store with microinstruction bus port and AXI4-Lite load path
// Operation
// RL1 - Word is 24 bits, two extended bits
// RL2 - Bits 17..0 driven in phase one only
// RL3 - Bits 21..18 active low, phases two-three
// RL4 - Never precharge any bus line
// RL5 - Extended bits out; bit 23 to trace
// RL6 - Eight-position switch selects address mode
// RL7 - Mode 1 answers 2000-3777 octal
// RL8 - Mode 2: two pages at 3000-3777
// RL9 - Reset bit forces page zero
// RL10 - Code 07 in 21..18 toggles page
// RL11 - Mode 3 swaps pages against mode 1
// RL12 - Mode 4 answers 0000-1777 octal
// RL13 - Host loads pages at fixed addresses
// RL14 - Microinstruction bus only reads store
// RL15 - Address in phase two, word after
// RL16 - Disable line skips next microcycle answer
// RL17 - Timing from phase two and four
// RL18 - Single cycle extended bits held cycle
// RL19 - Multi cycle extended bits cleared phase three
// RL20 - Enable bit low: no bus response
// RL21 - 1024 static words, no refresh
// RL22 - Outside range or disabled: undriven
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
module microcode_store_port
  import microcode_store_pkg::*;
#(
  parameter int unsigned ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SWITCH_W-1:0] address_switch,
  input wire logic phase_two,
  input wire logic phase_four,
  input wire logic [BUS_W-1:0] microinstruction_bus_in,
  output logic [BUS_W-1:0] microinstruction_bus_out,
  output logic [BUS_W-1:0] microinstruction_bus_oe_n,
  output logic [1:0] extended_control,
  output logic trace_stop_bit
);
  // ****************************************
  // Parameter check
  // ****************************************
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 4 and 32");
  end

  localparam int unsigned PIN_W = BUS_W + 2 + SWITCH_W;

  // ****************************************
  // Functions
  // ****************************************
  // Register decode: valid flag and index, shared by read and write
  function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] word_index;
    word_index = a[ADDR_W-1:2];
    reg_decode = {(a[1:0] == 2'b00) && (word_index <= (ADDR_W-2)'(LAST_INDEX)), word_index[1:0]};
  endfunction : reg_decode

  // Switch decode; unknown settings answer nothing
  function automatic map_mode_t switch_decode(input logic [SWITCH_W-1:0] sw);
    switch_decode = MAP_NONE;
    if (sw == SWITCH_MODE1) begin
      switch_decode = MAP_MODE1;
    end else if (sw == SWITCH_MODE2) begin
      switch_decode = MAP_MODE2;
    end else if (sw == SWITCH_MODE3) begin
      switch_decode = MAP_MODE3;
    end else if (sw == SWITCH_MODE4) begin
      switch_decode = MAP_MODE4;
    end
  endfunction : switch_decode

  // ****************************************
  // Storage and state
  // ****************************************
  logic [15:0] store_low [STORE_DEPTH];
  logic [7:0] store_high [STORE_DEPTH];
  logic [PIN_W-1:0] pin_s1, pin_s2, pin_s3, pin_clean;
  logic prev_two, prev_four;
  phase_t phase;
  logic [MADDR_W-1:0] fetch_addr;
  logic [IDX_W-1:0] fetch_idx;
  logic fetch_hit;
  logic [WORD_W-1:0] fetch_word;
  logic store_disable_seen;
  logic responding;
  logic page;
  logic [3:0] control_status_word;
  logic [IDX_W-1:0] host_addr;
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Three stages; a bit changes only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_clean <= '0;
    end else begin
      pin_s1 <= {address_switch, phase_four, phase_two, microinstruction_bus_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_clean);
    end
  end

  logic [BUS_W-1:0] bus_clean;
  logic two_clean, four_clean;
  map_mode_t mode;
  assign bus_clean = pin_clean[BUS_W-1:0];
  assign two_clean = pin_clean[BUS_W];
  assign four_clean = pin_clean[BUS_W+1];
  assign mode = switch_decode(pin_clean[PIN_W-1:BUS_W+2]); // see RL6

  // ****************************************
  // Phase tracking
  // ****************************************
  // Only the two clock phases reach us; the other two are inferred
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_two <= 1'b0;
      prev_four <= 1'b0;
    end else begin
      prev_two <= two_clean;
      prev_four <= four_clean;
    end
  end

  logic ev_latch, ev_ph1, ev_ph2, ev_ph4;
  assign ev_ph2 = (phase == PHASE_ONE) && two_clean && !prev_two;
  assign ev_latch = (phase == PHASE_TWO) && !two_clean && prev_two;
  assign ev_ph4 = (phase == PHASE_THREE) && four_clean && !prev_four;
  assign ev_ph1 = (phase == PHASE_FOUR) && !four_clean && prev_four;

  // Phase sequence driven from clean edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= PHASE_ONE;
    end else begin
      unique case (phase)
        PHASE_ONE: if (ev_ph2) phase <= PHASE_TWO; // see RL17
        PHASE_TWO: if (ev_latch) phase <= PHASE_THREE;
        PHASE_THREE: if (ev_ph4) phase <= PHASE_FOUR;
        PHASE_FOUR: if (ev_ph1) phase <= PHASE_ONE; // see RL17
      endcase
    end
  end

  // ****************************************
  // Address map
  // ****************************************
  logic map_hit;
  logic [IDX_W-1:0] map_idx;
  logic [MADDR_W-1:0] maddr;
  assign maddr = bus_clean[MADDR_W-1:0];

  // Microaddress to store location per mode
  always_comb begin
    map_hit = 1'b0;
    map_idx = maddr[IDX_W-1:0];
    unique case (mode)
      MAP_MODE1: map_hit = maddr[10]; // see RL7
      MAP_MODE2: begin
        map_hit = maddr[10] && maddr[9]; // see RL8
        map_idx = {page, maddr[8:0]};
      end
      MAP_MODE3: begin
        map_hit = maddr[10]; // see RL11
        map_idx = {!maddr[9], maddr[8:0]};
      end
      MAP_MODE4: map_hit = !maddr[10]; // see RL12
      MAP_NONE: map_hit = 1'b0;
      default: map_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Fetch and store disable
  // ****************************************
  // Address sampled at the end of phase two, word read at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_addr <= '0;
      fetch_idx <= '0;
      fetch_hit <= 1'b0;
      fetch_word <= '0;
    end else if (ev_latch) begin
      fetch_addr <= maddr; // see RL15
      fetch_idx <= map_idx;
      fetch_hit <= map_hit;
      fetch_word <= {store_high[map_idx], store_low[map_idx]}; // see RL1
    end
  end

  // Disable line seen in phase three suppresses the next answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_disable_seen <= 1'b0;
    end else if (phase == PHASE_THREE && bus_clean[STORE_DISABLE_LINE]) begin
      store_disable_seen <= 1'b1; // see RL16
    end else if (ev_ph1) begin
      store_disable_seen <= 1'b0;
    end
  end

  logic next_respond;
  assign next_respond = fetch_hit && control_status_word[ENABLE_BIT-12] && !store_disable_seen; // see RL20

  // Answer flag held for one whole microcycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      responding <= 1'b0;
    end else if (ev_ph1) begin
      responding <= next_respond; // see RL22
    end
  end

  // ****************************************
  // Bus drive
  // ****************************************
  // Lines are driven only with data; no precharge, low lines released in phase two, high lines in phase four
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      microinstruction_bus_out <= '0;
      microinstruction_bus_oe_n <= '1;
    end else if (ev_ph1 && next_respond) begin
      microinstruction_bus_out[17:0] <= fetch_word[17:0]; // see RL2
      microinstruction_bus_oe_n[17:0] <= '0; // see RL4
    end else if (ev_ph2) begin
      // Low lines freed for the next address
      microinstruction_bus_oe_n[17:0] <= '1; // see RL15
      microinstruction_bus_out[17:0] <= '0;
      if (responding) begin
        microinstruction_bus_out[21:18] <= ~fetch_word[21:18]; // see RL3
        microinstruction_bus_oe_n[21:18] <= '0;
      end
    end else if (ev_ph4) begin
      microinstruction_bus_oe_n <= '1; // see RL3
      microinstruction_bus_out <= '0;
    end
  end

  // ****************************************
  // Extended control outputs
  // ****************************************
  // Latched each phase one; cleared once a multi-cycle word shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extended_control <= 2'b00;
      trace_stop_bit <= 1'b0;
    end else if (ev_ph1) begin
      extended_control <= next_respond ? fetch_word[23:22] : 2'b00; // see RL18
      trace_stop_bit <= next_respond && fetch_word[23]; // see RL5
    end else if (phase == PHASE_THREE && bus_clean[STORE_DISABLE_LINE]) begin
      extended_control <= 2'b00; // see RL19
      trace_stop_bit <= 1'b0;
    end
  end

  // ****************************************
  // Page logic
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page <= 1'b0;
    end else if (control_status_word[RESET_BIT-12]) begin
      page <= 1'b0; // see RL9
    end else if (ev_ph1 && next_respond && mode == MAP_MODE2 && fetch_word[21:18] == PAGE_TOGGLE_CODE) begin
      page <= !page; // see RL10
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  logic write_fire;
  logic [2:0] wdec;
  logic host_ok;
  assign write_fire = aw_held && w_held && !s_axi_bvalid;
  assign wdec = reg_decode(aw_addr);
  assign host_ok = !control_status_word[ENABLE_BIT-12];

  // Address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (write_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wdec[2] ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control status word; address field is writable only while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_status_word <= CONTROL_RESET_VALUE;
      host_addr <= ADDR_RESET_VALUE;
    end else if (write_fire && wdec == {1'b1, STATUS_INDEX}) begin
      if (w_strb[1]) begin
        control_status_word <= w_data[RESET_BIT:ENABLE_BIT];
      end
      if (w_strb[0] && host_ok) begin
        host_addr[7:0] <= w_data[7:0];
      end
      if (w_strb[1] && host_ok) begin
        host_addr[9:8] <= w_data[9:8];
      end
    end
  end

  // Host loading; page 0 low half, page 1 high half in every mode
  always_ff @(posedge aclk) begin
    if (write_fire && host_ok && wdec == {1'b1, LOAD_LOW_INDEX}) begin
      if (w_strb[0]) begin
        store_low[host_addr][7:0] <= w_data[7:0]; // see RL13
      end
      if (w_strb[1]) begin
        store_low[host_addr][15:8] <= w_data[15:8]; // see RL21
      end
    end
    if (write_fire && host_ok && wdec == {1'b1, LOAD_HIGH_INDEX} && w_strb[0]) begin
      store_high[host_addr] <= w_data[7:0]; // see RL14
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  logic [2:0] rdec;
  logic [31:0] read_value;
  assign rdec = reg_decode(s_axi_araddr);

  // While enabled the fields show the last microbus fetch
  always_comb begin
    read_value = 32'h0000_0000;
    if (rdec == {1'b1, STATUS_INDEX}) begin
      read_value[RESET_BIT:ENABLE_BIT] = control_status_word;
      read_value[9:0] = host_ok ? host_addr : fetch_addr[9:0];
    end else if (rdec == {1'b1, LOAD_LOW_INDEX}) begin
      read_value[15:0] = host_ok ? store_low[host_addr] : fetch_word[15:0];
    end else if (rdec == {1'b1, LOAD_HIGH_INDEX}) begin
      read_value[7:0] = host_ok ? store_high[host_addr] : fetch_word[23:16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= rdec[2] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter_one;
    (phase == PHASE_FOUR) ##1 (phase == PHASE_ONE);
  endsequence

  property p_low_window;
    (microinstruction_bus_oe_n[17:0] != '1) |-> (phase == PHASE_ONE) && responding;
  endproperty
  a_low_window: assert property (p_low_window) else $error("low lines driven outside phase one"); // see RL2

  property p_high_window;
    (microinstruction_bus_oe_n[21:18] != '1) |-> (phase == PHASE_TWO || phase == PHASE_THREE);
  endproperty
  a_high_window: assert property (p_high_window) else $error("high lines driven outside two-three"); // see RL3

  // The next fetch overwrites the word register in phase two, so compare against the word held at drive start
  property p_high_level;
    (ev_ph2 && responding) |=> (microinstruction_bus_oe_n[21:18] == 4'h0)
      && (microinstruction_bus_out[21:18] == ~$past(fetch_word[21:18]));
  endproperty
  a_high_level: assert property (p_high_level) else $error("high lines not active low"); // see RL3

  property p_disable_skip;
    (store_disable_seen && phase == PHASE_FOUR) ##1 (phase == PHASE_ONE) |-> !responding;
  endproperty
  a_disable_skip: assert property (p_disable_skip) else $error("answered in disabled cycle"); // see RL16

  property p_enable_gate;
    (!control_status_word[ENABLE_BIT-12] throughout s_enter_one) |-> !responding;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("answered while disabled"); // see RL20

  property p_page_toggle;
    (ev_ph1 && next_respond && mode == MAP_MODE2 && fetch_word[21:18] == PAGE_TOGGLE_CODE
      && !control_status_word[RESET_BIT-12]) |=> (page != $past(page));
  endproperty
  a_page_toggle: assert property (p_page_toggle) else $error("page did not toggle"); // see RL10

  property p_page_reset;
    control_status_word[RESET_BIT-12] |=> !page;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("page not held at zero"); // see RL9

  property p_ext_latch;
    ev_ph1 |=> (extended_control == ($past(next_respond) ? $past(fetch_word[23:22]) : 2'b00));
  endproperty
  a_ext_latch: assert property (p_ext_latch) else $error("extended bits wrong at phase one"); // see RL18

  property p_ext_clear;
    (phase == PHASE_THREE && bus_clean[STORE_DISABLE_LINE]) |=> (extended_control == 2'b00) && !trace_stop_bit;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("extended bits not cleared"); // see RL19

  property p_mode1_map;
    (ev_latch && mode == MAP_MODE1 && maddr[10]) |=> fetch_hit && (fetch_idx == $past(maddr[9:0]));
  endproperty
  a_mode1_map: assert property (p_mode1_map) else $error("mode 1 mapping wrong"); // see RL7

endmodule : microcode_store_port

// ===== bench/cpu_bus_model.sv
// Processor-side model: clock phases, microaddress and store-disable drive
module cpu_bus_model
  import microcode_store_pkg::*;
(
  input wire logic aclk,
  input wire logic run,
  input wire logic [10:0] addr,
  input wire logic store_disable,
  input wire logic [BUS_W-1:0] dev_out,
  input wire logic [BUS_W-1:0] dev_oe_n,
  output logic phase_two,
  output logic phase_four,
  output logic [BUS_W-1:0] bus_in,
  output logic [4:0] slot
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [BUS_W-1:0] last = '0;
  logic [BUS_W-1:0] mine;
  logic drv;
  // Four phases of eight clocks each; slot[4:3] names the phase
  always_ff @(posedge aclk) begin
    slot <= run ? slot + 5'h01 : 5'h00;
    last <= bus_in;
  end
  assign phase_two = run && slot[4:3] == 2'h1;
  assign phase_four = run && slot[4:3] == 2'h3;
  // Drive starts late in phase two so it never fights the device's phase-one word
  assign drv = run && slot >= 5'h0e;
  assign mine = {5'h00, store_disable, 5'h00, addr};
  // Released lines show the inverse of their last level, never a stale copy
  assign bus_in = (~dev_oe_n & dev_out) | (dev_oe_n & (drv ? (22'h0107ff & mine) | (22'h3ef800 & ~last) : ~last));
endmodule : cpu_bus_model

// ===== bench/tb_top.sv
// Self-checking bench for the microcode store port
module tb_top
  import microcode_store_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals and bench state
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] address_switch = 8'h00;
  logic [10:0] ma = 11'h000;
  logic mc = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ext;
  logic [31:0] s_axi_rdata;
  logic [21:0] bout, oe_n, microinstruction_bus_in;
  logic phase_two, phase_four, trc;
  logic [4:0] slot;
  logic [23:0] mem [0:1023];
  logic [31:0] seed = 32'h9f5b;
  logic [23:0] pw = 24'h0;
  logic pend = 1'b0, page = 1'b0, en = 1'b0;
  int mode = 0;
  int fail_count = 0;
  int samples_checked = 0;
  int md_t [7] = '{2, 1, 2, 3, 4, 0, 4};
  logic [7:0] sw_t [7] = '{SWITCH_MODE2, SWITCH_MODE1, SWITCH_MODE2, SWITCH_MODE3, SWITCH_MODE4, 8'h03, SWITCH_MODE4};
  logic [10:0] cn [7] = '{11'h600, 11'h600, 11'h3ff, 11'h400, 11'h5ff, 11'h7ff, 11'h000};

  always #50 aclk = ~aclk;

  // Write strobes tied: only the low two lanes matter to this block
  microcode_store_port uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .address_switch, .phase_two, .phase_four, .microinstruction_bus_in,
    .microinstruction_bus_out(bout), .microinstruction_bus_oe_n(oe_n), .extended_control(ext),
    .trace_stop_bit(trc)
  );

  cpu_bus_model cpu (
    .aclk, .run(aresetn), .addr(ma), .store_disable(mc), .dev_out(bout), .dev_oe_n(oe_n),
    .phase_two, .phase_four, .bus_in(microinstruction_bus_in), .slot
  );

  // ****************************************
  // Helpers, bus cycles and compares
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Returns {hit, store index} for a microaddress in the current mode
  function automatic logic [10:0] map(input logic [10:0] a);
    case (mode)
      1: return {a[10], a[9:0]};
      2: return {a[10] & a[9], page, a[8:0]};
      3: return {a[10], ~a[9], a[8:0]};
      4: return {~a[10], a[9:0]};
      default: return 11'h000;
    endcase
  endfunction : map

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t resp %h exp %h", $time, got, exp);
    end
  endtask : check_resp

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check_resp(s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check_resp(s_axi_rresp, er);
    check_val(s_axi_rdata, ed);
  endtask : rd

  task automatic at(input logic [4:0] s);
    do @(negedge aclk); while (slot !== s);
  endtask : at

  // One microcycle: checks the answer to the previous address, then offers a new one
  task automatic mcycle(input logic [10:0] a, input logic c);
    logic [10:0] m;
    logic [1:0] e;
    e = pend ? pw[23:22] : 2'b00;
    at(5'd7);
    check_val(32'({oe_n, ext, trc}), 32'({pend ? 22'h3c0000 : 22'h3fffff, e, e[1]}));
    if (pend) check_val(32'(bout[17:0]), 32'(pw[17:0]));
    @(posedge aclk);
    ma <= a;
    mc <= c;
    at(5'd15);
    check_val(32'({oe_n, bout[21:18], ext}), 32'({pend ? 22'h03ffff : 22'h3fffff, pend ? ~pw[21:18] : 4'h0, e}));
    at(5'd31);
    check_val(32'({oe_n, ext}), 32'({22'h3fffff, c ? 2'b00 : e}));
    // Page flips on the answered word, so this address already sees the new page
    if (pend && mode == 2 && pw[21:18] == PAGE_TOGGLE_CODE) page = ~page;
    m = map(a);
    pend = en && m[10] && !c;
    pw = mem[m[9:0]];
  endtask : mcycle

  // Close the session with disable held, then reconfigure with the page reset
  task automatic setup(input int md, input logic [7:0] sw, input logic e);
    mcycle(11'h000, 1'b1);
    wr(4'h0, 32'h0, RESP_OKAY);
    address_switch <= sw;
    mode = md;
    en = e;
    page = 1'b0;
    wr(4'h0, {16'h0, 1'b1, 2'b00, e, 12'h000}, RESP_OKAY);
    wr(4'h0, {19'h0, e, 12'h000}, RESP_OKAY);
    wr(4'h4, 32'h0000_5a5a, RESP_OKAY);
    if (!e) mem[0][15:0] = 16'h5a5a;
  endtask : setup

  task automatic print_verdict();
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Full load with readback; each page start carries the toggle code
    for (int i = 0; i < STORE_DEPTH; i++) begin
      seed = lfsr(seed);
      mem[i] = seed[23:0];
      if (i[8:0] == 9'h000) mem[i][21:18] = PAGE_TOGGLE_CODE;
      wr(4'h0, 32'(i), RESP_OKAY);
      wr(4'h4, {seed[31:16], mem[i][15:0]}, RESP_OKAY);
      wr(4'h8, {24'h0, mem[i][23:16]}, RESP_OKAY);
      rd(4'h4, {16'h0, mem[i][15:0]}, RESP_OKAY);
      rd(4'h8, {24'h0, mem[i][23:16]}, RESP_OKAY);
    end
    $display("Load done");
    wr(4'h0, 32'h0000_0fff, RESP_OKAY);
    rd(4'h0, 32'h0000_03ff, RESP_OKAY);
    wr(4'hc, 32'h0000_1234, RESP_SLVERR);
    rd(4'hc, 32'h0, RESP_SLVERR);
    for (int s = 0; s < 7; s++) begin
      setup(md_t[s], sw_t[s], s < 6);
      foreach (cn[k]) mcycle(cn[k], 1'b0);
      repeat (20) begin
        seed = lfsr(seed);
        mcycle(seed[10:0], seed[15:13] == 3'h0);
      end
      // Enabled: address field shows the last latched microaddress
      rd(4'h0, {16'h0, 3'h0, en, 2'h0, en ? seed[9:0] : 10'h000}, RESP_OKAY);
      $display("Session %0d done", s);
    end
    mcycle(11'h000, 1'b1);
    wr(4'h0, 32'h0, RESP_OKAY);
    rd(4'h4, {16'h0, mem[0][15:0]}, RESP_OKAY);
    print_verdict();
  end

  // Hang guard, about two and a half times the expected run length
  initial begin
    #6_000_000;
    fail_count++;
    print_verdict();
  end
endmodule : tb_top
